/* logic/spp_fifo.sv */
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock, synchronous active-low reset, depth a power of two.
`timescale 1ns/1ps
module spp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             push;
  logic             pop;
  logic             full;
  logic             empty;

  ////////////////////////////////////////////////////////////////////
  // Extra pointer bit tells full from empty
  assign full      = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                     (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign empty     = (wr_ptr_reg == rd_ptr_reg);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem_reg[rd_ptr_reg[AW-1:0]];
  assign push      = in_valid && !full;
  assign pop       = out_ready && !empty;

  // Storage, no reset needed on data
  always_ff @(posedge clock) begin
    if (push) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + (AW+1)'(push);
      rd_ptr_reg <= rd_ptr_reg + (AW+1)'(pop);
    end
  end

endmodule

/* logic/spp_map.svh */
// Constants of the serial programming port: command bytes, field
// positions, reset values and sizes.
// Assumes inclusion by bare name from design and bench files.
`ifndef SPP_MAP_SVH
`define SPP_MAP_SVH

// Framing
`define SPP_PREAMBLE     8'haa
`define SPP_BIT_LAST     3'h7
`define SPP_BIT_FIRST    3'h0

// Opcodes that return data
`define SPP_OP_RD_CODE   8'h30
`define SPP_OP_RD_USIG   8'h32
`define SPP_OP_RD_MSIG   8'h38
`define SPP_OP_RD_STAT   8'h60
`define SPP_OP_RD_FUSE   8'h61
`define SPP_OP_RD_LOCK   8'h64

// Opcodes that carry data into the array
`define SPP_OP_WR_USIG   8'h52
`define SPP_OP_WR_LOCK   8'he4
`define SPP_OP_WR_FUSE   8'he1

// Position of the port enable bit in the fuse byte
`define SPP_FUSE_EN_BIT  0

// Page offset field of the address
`define SPP_OFS_W        5
`define SPP_ADDR_W       16

// Data path buffer
`define SPP_FIFO_DEPTH   8
`define SPP_FIFO_WIDTH   8

// Reset values
`define SPP_ADDR_RST     16'h0000
`define SPP_BYTE_RST     8'h00
`define SPP_CNT_RST      3'h0
`define SPP_SYNC_RST     3'h1

`endif

/* logic/spp_pkg.sv */
// Types shared by the serial programming port files.
// Assumes spp_map.svh for the constants.
package spp_pkg;

  typedef logic [7:0] spp_byte_t;

  // Command decode states
  typedef enum logic [2:0] {
    SPP_ST_PRE  = 3'h0,
    SPP_ST_OPC  = 3'h1,
    SPP_ST_ADH  = 3'h2,
    SPP_ST_ADL  = 3'h3,
    SPP_ST_DATA = 3'h4,
    SPP_ST_RDW  = 3'h5,
    SPP_ST_SKIP = 3'h6
  } spp_state_e;

endpackage

/* logic/spp_port.sv */
// Serial programming port: shifts command bytes in from the
// programmer, decodes them and drives the nonvolatile array side.
// Assumes sck comes from the programmer and may stop between frames;
// the array holds read data valid in the cycle that rd_req is high.
`timescale 1ns/1ps
`include "spp_map.svh"
module spp_port (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        por_n,
  input  wire logic        sck,
  input  wire logic        ss_n,
  input  wire logic        mosi,
  input  wire logic        prog_pin,
  input  wire logic        fuse_en,
  input  wire logic        busy,
  input  wire logic [7:0]  rd_data,
  output logic             miso,
  output logic             miso_oe,
  output logic             run,
  output logic             exec_pulse,
  output logic [7:0]       opcode,
  output logic [15:0]      addr,
  output logic [7:0]       wdata,
  output logic             wr_load,
  output logic             rd_req,
  output logic             overrun
);

  ////////////////////////////////////////////////////////////////////
  // Declarations
  logic [2:0]           cnt_reg;
  logic [7:0]           shift_reg;
  logic [7:0]           rx_byte_reg;
  logic                 rx_tgl_reg;
  logic [7:0]           tx_reg;
  logic                 miso_reg;
  logic [2:0]           meta_reg;
  logic [2:0]           sync_reg;
  logic                 ss_prev_reg;
  logic                 tgl_seen_reg;
  logic                 fuse_lat_reg;
  logic                 cap_done_reg;
  logic                 end_pend_reg;
  logic                 miso_oe_reg;
  logic                 run_reg;
  logic                 overrun_reg;
  logic [7:0]           reply_reg;
  logic [7:0]           reply_next;
  spp_pkg::spp_state_e  state_reg;
  spp_pkg::spp_state_e  state_next;
  logic [7:0]           opcode_reg;
  logic [7:0]           opcode_next;
  logic [15:0]          addr_reg;
  logic [15:0]          addr_next;
  logic [7:0]           wdata_reg;
  logic [7:0]           wdata_next;
  logic                 wr_load_reg;
  logic                 wr_next;
  logic                 rd_req_reg;
  logic                 rd_next;
  logic                 exec_reg;
  logic                 exec_next;
  logic                 ss_sync;
  logic                 tgl_sync;
  logic                 pin_sync;
  logic                 active;
  logic                 byte_evt;
  logic                 push_req;
  logic                 fifo_in_ready;
  logic                 fifo_out_valid;
  logic [7:0]           fifo_out_data;
  logic                 pop;
  logic                 ss_rise;
  logic                 end_ready;
  logic                 op_is_read;
  logic                 op_is_fuse;
  logic [7:0]           rx_word;

  ////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Opcodes that answer with data on the output line
  function automatic logic is_read(input logic [7:0] op);
    is_read = (op == `SPP_OP_RD_CODE) || (op == `SPP_OP_RD_USIG) ||
              (op == `SPP_OP_RD_MSIG) || (op == `SPP_OP_RD_STAT) ||
              (op == `SPP_OP_RD_FUSE) || (op == `SPP_OP_RD_LOCK);
  endfunction

  // Offset steps inside the page, page bits untouched
  function automatic logic [15:0] next_offset(input logic [15:0] a);
    next_offset = {a[15:`SPP_OFS_W],
                   a[`SPP_OFS_W-1:0] + `SPP_OFS_W'(1)};
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Link side, on the programmer's clock

  assign rx_word = {shift_reg[6:0], mosi};

  // Bit counter and input shifter; select high drops a partial byte
  always_ff @(posedge sck or posedge ss_n) begin
    if (ss_n) begin
      cnt_reg   <= `SPP_CNT_RST;
      shift_reg <= `SPP_BYTE_RST;
    end else begin
      cnt_reg   <= cnt_reg + 3'h1;
      shift_reg <= rx_word;
    end
  end

  // Whole byte held stable and flagged by a toggle for the core
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      rx_byte_reg <= `SPP_BYTE_RST;
      rx_tgl_reg  <= 1'b0;
    end else if (!ss_n && cnt_reg == `SPP_BIT_LAST) begin
      rx_byte_reg <= rx_word;
      rx_tgl_reg  <= !rx_tgl_reg;
    end
  end

  // Reply shifter; reply_reg is written long before a byte starts,
  // so it is stable when sampled here
  always_ff @(negedge sck or posedge ss_n) begin
    if (ss_n) begin
      tx_reg   <= `SPP_BYTE_RST;
      miso_reg <= 1'b0;
    end else if (cnt_reg == `SPP_BIT_FIRST) begin
      tx_reg   <= {reply_reg[6:0], 1'b0};
      miso_reg <= reply_reg[7];
    end else begin
      tx_reg   <= {tx_reg[6:0], 1'b0};
      miso_reg <= tx_reg[7];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Crossings into the core clock

  // Two flops per pin and per toggle; first stage feeds only the second
  for (genvar i = 0; i < 3; i++) begin : g_sync
    logic src;
    if (i == 0) begin : g_ss
      assign src = ss_n;
    end else if (i == 1) begin : g_tgl
      assign src = rx_tgl_reg;
    end else begin : g_pin
      assign src = prog_pin;
    end
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        meta_reg[i] <= 1'(`SPP_SYNC_RST >> i);
        sync_reg[i] <= 1'(`SPP_SYNC_RST >> i);
      end else begin
        meta_reg[i] <= src;
        sync_reg[i] <= meta_reg[i];
      end
    end
  end

  assign ss_sync  = sync_reg[0];
  assign tgl_sync = sync_reg[1];
  assign pin_sync = sync_reg[2];

  ////////////////////////////////////////////////////////////////////
  // Enable fuse, caught once per power-on only

  // Device reset pin does not touch this, only power-on does
  always_ff @(posedge clock) begin
    if (!por_n) begin
      fuse_lat_reg <= 1'b0;
      cap_done_reg <= 1'b0;
    end else if (!cap_done_reg) begin
      fuse_lat_reg <= fuse_en;
      cap_done_reg <= 1'b1;
    end
  end

  // Session runs only with prog_pin high and fuse latched on
  assign active   = fuse_lat_reg && pin_sync;
  assign byte_evt = tgl_sync != tgl_seen_reg;
  assign push_req = byte_evt && active;
  assign ss_rise  = ss_sync && !ss_prev_reg;

  ////////////////////////////////////////////////////////////////////
  // Byte buffer; the decoder stalls on busy so it can fill

  spp_fifo #(
    .WIDTH (`SPP_FIFO_WIDTH),
    .DEPTH (`SPP_FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (push_req),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_byte_reg),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data)
  );

  assign pop        = fifo_out_valid && !busy && state_reg != spp_pkg::SPP_ST_RDW;
  assign end_ready  = end_pend_reg && !fifo_out_valid && !busy &&
                      state_reg != spp_pkg::SPP_ST_RDW;
  assign op_is_read = is_read(opcode_reg);
  assign op_is_fuse = opcode_reg == `SPP_OP_WR_FUSE;

  ////////////////////////////////////////////////////////////////////
  // Command decoder
  always_comb begin
    state_next  = state_reg;
    opcode_next = opcode_reg;
    addr_next   = addr_reg;
    wdata_next  = wdata_reg;
    reply_next  = reply_reg;
    wr_next     = 1'b0;
    rd_next     = 1'b0;
    exec_next   = 1'b0;
    if (wr_load_reg || state_reg == spp_pkg::SPP_ST_RDW) begin
      addr_next = next_offset(addr_reg);
    end
    if (!active) begin
      state_next = spp_pkg::SPP_ST_PRE;
    end else if (state_reg == spp_pkg::SPP_ST_RDW) begin
      reply_next = rd_data;
      state_next = spp_pkg::SPP_ST_DATA;
    end else if (pop) begin
      unique case (state_reg)
        spp_pkg::SPP_ST_PRE: begin
          state_next = (fifo_out_data == `SPP_PREAMBLE) ?
                       spp_pkg::SPP_ST_OPC : spp_pkg::SPP_ST_SKIP;
        end
        spp_pkg::SPP_ST_OPC: begin
          opcode_next = fifo_out_data;
          state_next  = spp_pkg::SPP_ST_ADH;
        end
        spp_pkg::SPP_ST_ADH: begin
          addr_next  = {fifo_out_data, addr_reg[7:0]};
          state_next = spp_pkg::SPP_ST_ADL;
        end
        spp_pkg::SPP_ST_ADL: begin
          addr_next  = {addr_reg[15:8], fifo_out_data};
          rd_next    = op_is_read;
          state_next = op_is_read ? spp_pkg::SPP_ST_RDW : spp_pkg::SPP_ST_DATA;
        end
        spp_pkg::SPP_ST_DATA: begin
          if (op_is_read) begin
            rd_next    = 1'b1;
            state_next = spp_pkg::SPP_ST_RDW;
          end else begin
            wr_next    = 1'b1;
            wdata_next = fifo_out_data;
            if (op_is_fuse) begin
              // Enable bit may go to zero but never back to one
              wdata_next[`SPP_FUSE_EN_BIT] = fifo_out_data[`SPP_FUSE_EN_BIT]
                                             && fuse_en;
            end
          end
        end
        spp_pkg::SPP_ST_SKIP: begin
          state_next = spp_pkg::SPP_ST_SKIP;
        end
        default: begin
          state_next = spp_pkg::SPP_ST_PRE;
        end
      endcase
    end else if (end_ready) begin
      exec_next  = state_reg == spp_pkg::SPP_ST_DATA;
      state_next = spp_pkg::SPP_ST_PRE;
    end
  end

  // Decoder registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg   <= spp_pkg::SPP_ST_PRE;
      opcode_reg  <= `SPP_BYTE_RST;
      addr_reg    <= `SPP_ADDR_RST;
      wdata_reg   <= `SPP_BYTE_RST;
      reply_reg   <= `SPP_BYTE_RST;
      wr_load_reg <= 1'b0;
      rd_req_reg  <= 1'b0;
      exec_reg    <= 1'b0;
    end else begin
      state_reg   <= state_next;
      opcode_reg  <= opcode_next;
      addr_reg    <= addr_next;
      wdata_reg   <= wdata_next;
      reply_reg   <= reply_next;
      wr_load_reg <= wr_next;
      rd_req_reg  <= rd_next;
      exec_reg    <= exec_next;
    end
  end

  // Frame end, pin levels and overrun flag
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tgl_seen_reg <= 1'b0;
      ss_prev_reg  <= 1'b1;
      end_pend_reg <= 1'b0;
      miso_oe_reg  <= 1'b0;
      run_reg      <= 1'b1;
      overrun_reg  <= 1'b0;
    end else begin
      tgl_seen_reg <= tgl_sync;
      ss_prev_reg  <= ss_sync;
      end_pend_reg <= active && !end_ready && (end_pend_reg || ss_rise);
      miso_oe_reg  <= active && !ss_sync;
      run_reg      <= !pin_sync;
      overrun_reg  <= overrun_reg || (push_req && !fifo_in_ready);
    end
  end

  assign miso       = miso_reg;
  assign miso_oe    = miso_oe_reg;
  assign run        = run_reg;
  assign exec_pulse = exec_reg;
  assign opcode     = opcode_reg;
  assign addr       = addr_reg;
  assign wdata      = wdata_reg;
  assign wr_load    = wr_load_reg;
  assign rd_req     = rd_req_reg;
  assign overrun    = overrun_reg;

  ////////////////////////////////////////////////////////////////////
  // Checks

  a_exec_after_end: assert property (@(posedge clock) disable iff (!rst_n)
    exec_reg |-> ss_sync && state_reg == spp_pkg::SPP_ST_PRE)
    else $error("command acted on before select rose");

  a_push_gated: assert property (@(posedge clock) disable iff (!rst_n)
    !(fuse_lat_reg && pin_sync) |=> !wr_load_reg && !rd_req_reg && !exec_reg)
    else $error("byte accepted while port disabled");

  a_fuse_held: assert property (@(posedge clock) disable iff (!por_n)
    cap_done_reg |=> $stable(fuse_lat_reg) && cap_done_reg)
    else $error("enable fuse changed without power cycle");

  a_fuse_no_set: assert property (@(posedge clock) disable iff (!rst_n)
    wr_load_reg && op_is_fuse && !$past(fuse_en)
      |-> !wdata_reg[`SPP_FUSE_EN_BIT])
    else $error("session set the enable fuse");

  a_offset_wrap: assert property (@(posedge clock) disable iff (!rst_n)
    wr_load_reg |=> addr_reg == next_offset($past(addr_reg)))
    else $error("page offset did not step");

  a_oe_released: assert property (@(posedge clock) disable iff (!rst_n)
    ss_sync |=> !miso_oe_reg)
    else $error("output driven with select high");

  a_reply_load: assert property (@(posedge clock) disable iff (!rst_n)
    rd_req_reg |=> reply_reg == $past(rd_data) ##1 !rd_req_reg)
    else $error("read data not taken for reply");

  a_run_on_exit: assert property (@(posedge clock) disable iff (!rst_n)
    !pin_sync ##1 !pin_sync |-> run_reg && !miso_oe_reg)
    else $error("execution not resumed after exit");

  a_msb_first: assert property (@(posedge sck) disable iff (ss_n || !rst_n)
    cnt_reg == `SPP_BIT_LAST |=> rx_byte_reg[0] == $past(mosi)
      && rx_byte_reg[7] == $past(shift_reg[6]))
    else $error("byte not assembled msb first");

  c_exec: cover property (@(posedge clock) disable iff (!rst_n) exec_reg);
  c_wrap: cover property (@(posedge clock) disable iff (!rst_n)
    wr_load_reg && addr_reg[4:0] == 5'h1f);
  c_read: cover property (@(posedge clock) disable iff (!rst_n)
    rd_req_reg ##[1:400] rd_req_reg);
  c_skip: cover property (@(posedge clock) disable iff (!rst_n)
    state_reg == spp_pkg::SPP_ST_SKIP);

endmodule

/* test/spp_prog_model.sv */
// Programmer model: drives select, serial clock and command bytes.
// Assumes the device drives miso only while miso_oe is high.
`timescale 1ns/1ps
module spp_prog_model (
  output logic      sck,
  output logic      ss_n,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic miso_oe
);
  spp_pkg::spp_byte_t rx_q[$];
  // Released output reads as the inverse of its last level
  wire              miso_line = miso_oe ? miso : ~miso;

  // Clock and select low while power comes up
  initial begin
    sck = 1'b0;
    ss_n = 1'b0;
    mosi = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////
  // Select high once reset is up; clock stays low between frames
  task automatic power_up();
    ss_n = 1'b1;
  endtask

  // Release data, clock low, then select low; reset is the bench's
  // and falls only after this returns, with select, a moment after the calling edge
  task automatic power_down();
    mosi = ~mosi;
    sck = 1'b0;
    #1 ss_n = 1'b0;
  endtask

  // One command; cut_bits >= 0 aborts after that many bits
  task automatic frame(input spp_pkg::spp_byte_t tx[$], input int cut_bits);
    spp_pkg::spp_byte_t b;
    int n;
    n = 0;
    b = 8'h00;
    rx_q = {};
    #3.7 ss_n = 1'b0;
    #100;
    foreach (tx[k]) begin
      for (int i = 7; i >= 0; i--) begin
        if (n == cut_bits) break;
        mosi = tx[k][i];
        #15 sck = 1'b1;
        b[i] = miso_line;
        #15 sck = 1'b0;
        n++;
      end
      rx_q.push_back(b);
    end
    #100 mosi = ~mosi;
    ss_n = 1'b1;
    #120;
  endtask
endmodule

/* test/tb_top.sv */
// Bench of the serial programming port: random and corner frames
// from a programmer model, an array model answering reads.
// Assumes spp_port, spp_fifo and spp_prog_model are compiled first.
`timescale 1ns/1ps
`include "spp_map.svh"
module tb_top;
  logic        clock, rst_n, por_n, prog_pin, fuse_en, busy;
  logic [7:0]  rd_data, opcode, wdata;
  logic [15:0] addr;
  logic        sck, ss_n, mosi, miso, miso_oe, run;
  logic        exec_pulse, wr_load, rd_req, overrun;
  int          err_total, comparisons, cycles, exec_cnt, bad_cnt;
  int          ss_hi, oe_cnt, seed;
  logic [23:0] wr_q[$];
  spp_pkg::spp_byte_t txq[$];
  localparam spp_pkg::spp_byte_t RD_OPS [6] = '{`SPP_OP_RD_CODE, `SPP_OP_RD_USIG,
    `SPP_OP_RD_MSIG, `SPP_OP_RD_STAT, `SPP_OP_RD_FUSE, `SPP_OP_RD_LOCK};
  localparam spp_pkg::spp_byte_t WR_OPS [3] = '{`SPP_OP_WR_USIG, `SPP_OP_WR_LOCK,
    `SPP_OP_WR_FUSE};

  spp_port i_spp_port (.clock(clock), .rst_n(rst_n), .por_n(por_n), .sck(sck),
    .ss_n(ss_n), .mosi(mosi), .prog_pin(prog_pin), .fuse_en(fuse_en), .busy(busy),
    .rd_data(rd_data), .miso(miso), .miso_oe(miso_oe), .run(run),
    .exec_pulse(exec_pulse), .opcode(opcode), .addr(addr), .wdata(wdata),
    .wr_load(wr_load), .rd_req(rd_req), .overrun(overrun));
  spp_prog_model u_prog (.sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe));

  always #2.5 clock = ~clock;

  // Array model reads combinationally: the decoder takes the byte in the
  // same cycle that rd_req stands, so a clocked answer would come too late
  assign rd_data = (rd_req === 1'b1) ? mem_val(addr) : 8'h00;

  //////////////////////////////////////////////////////////////////////
  // Array content is a pure function of the address
  function automatic logic [7:0] mem_val(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction

  // Fuse writes can only clear the enable bit
  function automatic logic [7:0] fz(input logic [7:0] op, input logic [7:0] d);
    return (op == `SPP_OP_WR_FUSE) ? {d[7:1], d[0] & fuse_en} : d;
  endfunction

  // Collect pulses, cut a hang short
  always @(posedge clock) begin
    cycles++;
    ss_hi = (ss_n === 1'b1) ? ss_hi + 1 : 0;
    if (miso_oe === 1'b1) oe_cnt++;
    if (wr_load === 1'b1) wr_q.push_back({addr, wdata});
    if (exec_pulse === 1'b1) exec_cnt++;
    if (exec_pulse === 1'b1 && ss_n !== 1'b1) bad_cnt++;
    if (ss_hi > 6 && miso_oe !== 1'b0) bad_cnt++;
    if (cycles == 40000) begin
      err_total++;
      summarize();
    end
  end

  // Output may move only while the serial clock is low
  always @(miso) if (ss_n === 1'b0 && sck === 1'b1) bad_cnt++;

  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Power cycle: fuse latched at the first edge after release
  task automatic restart(input logic fuse);
    @(posedge clock);
    prog_pin <= 1'b0;
    u_prog.power_down();
    rst_n <= 1'b0;
    por_n <= 1'b0;
    fuse_en <= fuse;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    prog_pin <= 1'b1;
    u_prog.power_up();
    repeat (40) @(posedge clock);  // shortened wait
  endtask

  // Two data bytes; the second lands at the next page offset
  task automatic t_write(input spp_pkg::spp_byte_t op, input logic [4:0] ofs);
    logic [15:0] a;
    spp_pkg::spp_byte_t d0, d1;
    a = 16'($random(seed));
    a[4:0] = ofs;
    d0 = 8'($random(seed));
    d1 = 8'($random(seed));
    wr_q = {};
    exec_cnt = 0;
    txq = {`SPP_PREAMBLE, op, a[15:8], a[7:0], d0, d1};
    u_prog.frame(txq, -1);
    check("wr count", 24'h2, 24'(wr_q.size()));
    check("wr first", {a, fz(op, d0)}, wr_q[0]);
    check("wr second", {a[15:5], ofs + 5'h01, fz(op, d1)}, wr_q[1]);
    check("wr exec", 24'h1, 24'(exec_cnt));
    check("opcode", {16'h0, op}, {16'h0, opcode});
    $display("test write %h done", op);
  endtask

  // Reply lags one byte: dummy five holds the first read
  task automatic t_read(input spp_pkg::spp_byte_t op);
    logic [15:0] a;
    a = 16'($random(seed));
    wr_q = {};
    exec_cnt = 0;
    txq = {`SPP_PREAMBLE, op, a[15:8], a[7:0], 8'h00, 8'h00, 8'h00};
    u_prog.frame(txq, -1);
    check("rd byte", {16'h0, mem_val(a)}, {16'h0, u_prog.rx_q[5]});
    check("rd next", {16'h0, mem_val({a[15:5], a[4:0] + 5'h01})},
      {16'h0, u_prog.rx_q[6]});
    check("rd no wr", 24'h0, 24'(wr_q.size()));
    check("rd exec", 24'h1, 24'(exec_cnt));
    $display("test read %h done", op);
  endtask

  // Frame that must leave no trace
  task automatic t_none(input spp_pkg::spp_byte_t pre, input int cut);
    wr_q = {};
    exec_cnt = 0;
    txq = {pre, `SPP_OP_WR_USIG, 8'h00, 8'h03, 8'h5a};
    u_prog.frame(txq, cut);
    check("no wr", 24'h0, 24'(wr_q.size()));
    check("no exec", 24'h0, 24'(exec_cnt));
    $display("test refused %h done", pre);
  endtask

  //////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    por_n = 1'b0;
    prog_pin = 1'b0;
    fuse_en = 1'b1;
    busy = 1'b0;
    seed = 54228;
    restart(1'b1);
    check("run low", 24'h0, {23'h0, run});
    foreach (WR_OPS[k]) t_write(WR_OPS[k], 5'h1f);
    repeat (4) t_write(`SPP_OP_WR_USIG, 5'($random(seed)));
    foreach (RD_OPS[k]) t_read(RD_OPS[k]);
    t_none(8'h55, -1);
    t_none(`SPP_PREAMBLE, 3);
    t_write(`SPP_OP_WR_USIG, 5'h00);
    // Live fuse cleared: port stays open, fuse write cannot set it
    @(posedge clock);
    fuse_en <= 1'b0;
    t_write(`SPP_OP_WR_FUSE, 5'h00);
    // Back in run mode the port is shut
    @(posedge clock);
    prog_pin <= 1'b0;
    repeat (6) @(posedge clock);
    check("run high", 24'h1, {23'h0, run});
    t_none(`SPP_PREAMBLE, -1);
    // Power cycle with the enable fuse clear
    restart(1'b0);
    oe_cnt = 0;
    t_none(`SPP_PREAMBLE, -1);
    check("oe shut", 24'h0, 24'(oe_cnt));
    // Stalled array: the buffer fills and refuses
    restart(1'b1);
    @(posedge clock);
    busy <= 1'b1;
    txq = {`SPP_PREAMBLE, `SPP_OP_WR_USIG, 8'h00, 8'h00};
    repeat (12) txq.push_back(8'($random(seed)));
    u_prog.frame(txq, -1);
    check("overrun set", 24'h1, {23'h0, overrun});
    @(posedge clock);
    busy <= 1'b0;
    repeat (60) @(posedge clock);
    check("overrun held", 24'h1, {23'h0, overrun});
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    repeat (10) @(posedge clock);
    check("overrun clear", 24'h0, {23'h0, overrun});
    $display("test buffer full done");
    check("monitors", 24'h0, 24'(bad_cnt));
    summarize();
  end
endmodule
